// File: include/ida_pkg.sv
package ida_pkg;
  // slot payload layout
  localparam int SLOT_BITS = 24;
  localparam int LIM_W = 12;
  localparam int LIM_BOTH_W = 11;
  localparam int BO_W = 13;
  localparam int MASK_W = 8;
  localparam int SLOT_IDX_W = 6;
  localparam int FUNC_W = 3;
  localparam int FRAME_SLOTS = 8;
  localparam logic [4:0] LAST_BIT = 5'(SLOT_BITS - 1);
  // wire bits between the device's synchronised sample and its next launch
  localparam logic [4:0] TX_LEAD = 5'h3;

  // shared pin roles
  localparam logic [FUNC_W-1:0] PIN_FN_ALIGN = 3'h0;
  localparam logic [FUNC_W-1:0] PIN_FN_OFF = 3'h1;
  localparam logic [FUNC_W-1:0] PIN_FN_GPIO = 3'h2;

  // link clock made by the controller
  localparam int CLK_PERIOD_NS = 8;
  localparam int BCLK_PERIOD_NS = 80;
  localparam int BCLK_HALF_CYC = (BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS) < 1) ? 1 :
                                 BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SLOT = 8'h04;
  localparam logic [7:0] REG_TXWORD = 8'h08;
  localparam logic [7:0] REG_CAPWORD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_TX_BIT = 1;
  localparam int CTRL_BUS_BIT = 2;
  localparam int SLOT_TX_LSB = 0;
  localparam int SLOT_CAP_LSB = 8;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [SLOT_IDX_W-1:0] TX_SLOT_RST = 6'h0;
  localparam logic [SLOT_IDX_W-1:0] CAP_SLOT_RST = 6'h0;
  localparam logic [SLOT_BITS-1:0] TXWORD_RST = 24'h0;

  function automatic logic [SLOT_BITS-1:0] ida_pack(input logic [LIM_W-1:0] lim, input logic [BO_W-1:0] bo,
                                                    input logic lim_en, input logic bo_en);
    if (lim_en && bo_en) ida_pack = {lim[LIM_W-1:1], bo};
    else if (lim_en) ida_pack = {lim, 12'h000};
    else if (bo_en) ida_pack = {11'h000, bo};
    else ida_pack = 24'h000000;
  endfunction

  function automatic logic [LIM_W-1:0] ida_lim(input logic [SLOT_BITS-1:0] w, input logic lim_en,
                                              input logic bo_en);
    if (lim_en && bo_en) ida_lim = {w[SLOT_BITS-1:BO_W], 1'b0};
    else if (lim_en) ida_lim = w[SLOT_BITS-1:SLOT_BITS-LIM_W];
    else ida_lim = 12'h000;
  endfunction

  function automatic logic [BO_W-1:0] ida_bo(input logic [SLOT_BITS-1:0] w, input logic bo_en);
    ida_bo = bo_en ? w[BO_W-1:0] : 13'h0000;
  endfunction
endpackage

// File: include/ida_link_if.sv
interface ida_link_if;
  logic bclk;
  logic fsync;
  logic pin_dev_out;
  logic pin_dev_oe_n;
  logic pin_ctl_out;
  logic pin_ctl_oe_n;
  logic sao_dev_out;
  logic sao_dev_oe_n;
  logic sao_ctl_out;
  logic sao_ctl_oe_n;
  logic pin_keep_en;
  logic sao_keep_en;
  logic pin;
  logic sao;

  // idle wires read low; the keeper enables are pad controls only
  assign pin = !pin_dev_oe_n ? pin_dev_out : (!pin_ctl_oe_n ? pin_ctl_out : 1'b0);
  assign sao = !sao_dev_oe_n ? sao_dev_out : (!sao_ctl_oe_n ? sao_ctl_out : 1'b0);

  modport dev (
    input bclk, fsync, pin, sao,
    output pin_dev_out, pin_dev_oe_n, sao_dev_out, sao_dev_oe_n, pin_keep_en, sao_keep_en
  );
  modport ctl (
    output bclk, fsync, pin_ctl_out, pin_ctl_oe_n, sao_ctl_out, sao_ctl_oe_n,
    input pin, sao
  );
endinterface

// File: src/ida_sync.sv
module ida_sync #(
  parameter int W = 1
) (
  input wire logic clk, // sampling clock
  input wire logic rst, // synchronous reset
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ida_sync_t;

  ida_sync_t st_r;
  ida_sync_t st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    if (rst) st_nxt = '0;
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign q = st_r.s2;
endmodule

// File: src/ida_dev.sv
// Contract
// - align limiter and brownout gain across devices
// - group membership chosen per device
// - send gain word in one 24-bit slot
// - both enabled: 11-bit limiter, 13-bit brownout
// - limiter only: 12-bit limiter field
// - group uses adjacent slots from first slot
// - own slot field, sent only when enabled
// - 8-bit mask picks listened slots
// - fewer than two listened: no alignment
// - separate limiter and brownout align enables
// - peers share identical protection settings
// - shared pin keeps audio slots free
// - shared pin uses bit clock, frame sync
// - separate keeper control for each pin
// - pin off or gpio: use serial out
// - 3-bit field selects pin role
module ida_dev #(
  parameter int FRAME_SLOTS = ida_pkg::FRAME_SLOTS
) (
  ida_link_if.dev lnk, // alignment link, clocked by its bit clock
  input wire logic rst, // synchronous reset, link clock domain
  input wire logic [ida_pkg::LIM_W-1:0] lim_gr, // own limiter gain reduction
  input wire logic [ida_pkg::BO_W-1:0] bo_gr, // own brownout gain reduction
  input wire logic gain_tx_enable, // send own word
  input wire logic [ida_pkg::SLOT_IDX_W-1:0] own_slot, // slot for own word
  input wire logic [ida_pkg::SLOT_IDX_W-1:0] group_first_slot, // first slot of group
  input wire logic [ida_pkg::MASK_W-1:0] listen_slot_mask, // listened group slots
  input wire logic limiter_align_enable, // limiter alignment on
  input wire logic brownout_align_enable, // brownout alignment on
  input wire logic [ida_pkg::FUNC_W-1:0] shared_pin_function, // pin role
  input wire logic align_keeper_enable, // keeper on shared pin
  input wire logic sao_keeper_enable, // keeper on serial out
  input wire logic gpio_out, // pin level in gpio role
  input wire logic gpio_oe_n, // pin drive in gpio role, low drives
  output logic gpio_in, // synchronised pin level
  output logic [ida_pkg::LIM_W-1:0] aligned_lim_gr, // limiter reduction to apply
  output logic [ida_pkg::BO_W-1:0] aligned_bo_gr // brownout reduction to apply
);
  import ida_pkg::*;

  localparam logic [SLOT_IDX_W-1:0] SLOT_MAX = SLOT_IDX_W'(FRAME_SLOTS - 1);

  typedef struct packed {
    logic [4:0] bit_r;
    logic [SLOT_IDX_W-1:0] slot_r;
    logic [SLOT_BITS-1:0] shift_r;
    logic [SLOT_BITS-1:0] tx_word_r;
    logic [LIM_W-1:0] acc_lim_r;
    logic [BO_W-1:0] acc_bo_r;
    logic [LIM_W-1:0] alim_r;
    logic [BO_W-1:0] abo_r;
    logic pin_out_r;
    logic pin_oe_n_r;
    logic sao_out_r;
    logic sao_oe_n_r;
    logic pin_keep_r;
    logic sao_keep_r;
    logic framed_r;
    logic tx_act_r;
  } ida_dev_t;

  ida_dev_t q;
  ida_dev_t n;

  logic rx_fs;
  logic rx_pin;
  logic rx_sao;
  logic rx_d;
  logic [4:0] cbit;
  logic [SLOT_IDX_W-1:0] cslot;
  logic [4:0] tsum;
  logic [4:0] tbit;
  logic [SLOT_IDX_W-1:0] tslot;
  logic [SLOT_BITS-1:0] word;
  logic [LIM_W-1:0] rx_lim;
  logic [BO_W-1:0] rx_bo;
  logic group_ok;
  logic active;
  logic txb;

  // frame sync and both data wires arrive from the far end's pads
  ida_sync #(.W(3)) u_sync (
    .clk(lnk.bclk),
    .rst(rst),
    .d({lnk.fsync, lnk.pin, lnk.sao}),
    .q({rx_fs, rx_pin, rx_sao})
  );

  // slot index relative to the group start, within the 8-slot window
  function automatic logic in_group(input logic [SLOT_IDX_W-1:0] slot, input logic [SLOT_IDX_W-1:0] first,
                                    input logic [MASK_W-1:0] mask);
    logic [SLOT_IDX_W-1:0] rel;
    rel = slot - first;
    in_group = (slot >= first) && (rel < SLOT_IDX_W'(MASK_W)) && mask[rel[2:0]];
  endfunction

  function automatic logic two_or_more(input logic [MASK_W-1:0] mask);
    logic [3:0] cnt;
    cnt = 4'h0;
    for (int i = 0; i < MASK_W; i++) begin
      cnt = cnt + {3'h0, mask[i]};
    end
    two_or_more = cnt >= 4'h2;
  endfunction

  always_comb begin
    n = q;
    // the shared pin carries traffic only in its alignment role
    rx_d = (shared_pin_function == PIN_FN_ALIGN) ? rx_pin : rx_sao;
    group_ok = two_or_more(listen_slot_mask);

    // position of the bit now at the synchroniser output
    if (rx_fs) begin
      cbit = 5'h0;
      cslot = '0;
    end else if (q.bit_r == LAST_BIT) begin
      cbit = 5'h0;
      cslot = (q.slot_r == SLOT_MAX) ? '0 : q.slot_r + 6'h1;
    end else begin
      cbit = q.bit_r + 5'h1;
      cslot = q.slot_r;
    end
    n.bit_r = cbit;
    n.slot_r = cslot;

    word = {q.shift_r[SLOT_BITS-2:0], rx_d};
    n.shift_r = word;
    rx_lim = ida_lim(word, limiter_align_enable, brownout_align_enable);
    rx_bo = ida_bo(word, brownout_align_enable);
    if (cbit == LAST_BIT && in_group(cslot, group_first_slot, listen_slot_mask)) begin
      if (rx_lim > q.acc_lim_r) n.acc_lim_r = rx_lim;
      if (rx_bo > q.acc_bo_r) n.acc_bo_r = rx_bo;
    end

    // results change once a frame so every peer switches on the same frame
    if (rx_fs) begin
      n.framed_r = 1'b1;
      n.alim_r = lim_gr;
      n.abo_r = bo_gr;
      if (group_ok && limiter_align_enable && q.acc_lim_r > lim_gr) n.alim_r = q.acc_lim_r;
      if (group_ok && brownout_align_enable && q.acc_bo_r > bo_gr) n.abo_r = q.acc_bo_r;
      n.acc_lim_r = '0;
      n.acc_bo_r = '0;
    end

    // launch runs ahead of the synchronised position by the two sync stages plus the output register
    tsum = cbit + TX_LEAD;
    if (tsum > LAST_BIT) begin
      tbit = tsum - 5'(SLOT_BITS);
      tslot = (cslot == SLOT_MAX) ? '0 : cslot + 6'h1;
    end else begin
      tbit = tsum;
      tslot = cslot;
    end
    // word frozen at its first bit so a slot never mixes two samples
    if (tbit == 5'h0 && tslot == own_slot) begin
      n.tx_word_r = ida_pack(lim_gr, bo_gr, limiter_align_enable, brownout_align_enable);
    end
    txb = n.tx_word_r[LAST_BIT - tbit];
    // whole slots only: enable and slot are taken at the slot's first bit, nothing goes out before framing
    if (tbit == 5'h0) n.tx_act_r = q.framed_r && gain_tx_enable && (tslot == own_slot);
    active = n.tx_act_r;

    n.pin_out_r = 1'b0;
    n.pin_oe_n_r = 1'b1;
    n.sao_out_r = 1'b0;
    n.sao_oe_n_r = 1'b1;
    case (shared_pin_function)
      PIN_FN_ALIGN: begin
        // audio serial out stays untouched while the pin carries alignment
        n.pin_out_r = active & txb;
        n.pin_oe_n_r = !active;
      end
      PIN_FN_GPIO: begin
        n.pin_out_r = gpio_out;
        n.pin_oe_n_r = gpio_oe_n;
        n.sao_out_r = active & txb;
        n.sao_oe_n_r = !active;
      end
      default: begin
        // off and unassigned codes both fall back to serial out
        n.sao_out_r = active & txb;
        n.sao_oe_n_r = !active;
      end
    endcase
    n.pin_keep_r = align_keeper_enable;
    n.sao_keep_r = sao_keeper_enable;

    if (rst) begin
      n = '0;
      n.pin_oe_n_r = 1'b1;
      n.sao_oe_n_r = 1'b1;
    end
  end

  always_ff @(posedge lnk.bclk) begin
    q <= n;
  end

  assign lnk.pin_dev_out = q.pin_out_r;
  assign lnk.pin_dev_oe_n = q.pin_oe_n_r;
  assign lnk.sao_dev_out = q.sao_out_r;
  assign lnk.sao_dev_oe_n = q.sao_oe_n_r;
  assign lnk.pin_keep_en = q.pin_keep_r;
  assign lnk.sao_keep_en = q.sao_keep_r;
  assign gpio_in = rx_pin;
  assign aligned_lim_gr = q.alim_r;
  assign aligned_bo_gr = q.abo_r;
endmodule

// File: src/ida_ctl.sv
module ida_ctl #(
  parameter int FRAME_SLOTS = ida_pkg::FRAME_SLOTS,
  parameter int BCLK_HALF = ida_pkg::BCLK_HALF_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  ida_link_if.ctl lnk // alignment link, clock made here
);
  import ida_pkg::*;

  localparam logic [SLOT_IDX_W-1:0] SLOT_MAX = SLOT_IDX_W'(FRAME_SLOTS - 1);
  localparam logic [7:0] DIV_LAST = 8'(BCLK_HALF - 1);

  typedef struct packed {
    logic [7:0] div_r;
    logic bclk_r;
    logic fsync_r;
    logic [4:0] bit_r;
    logic [SLOT_IDX_W-1:0] slot_r;
    logic [SLOT_BITS-1:0] shift_r;
    logic pin_out_r;
    logic pin_oe_n_r;
    logic sao_out_r;
    logic sao_oe_n_r;
    logic [2:0] ctrl_r;
    logic [SLOT_IDX_W-1:0] tx_slot_r;
    logic [SLOT_IDX_W-1:0] cap_slot_r;
    logic [SLOT_BITS-1:0] txword_r;
    logic [SLOT_BITS-1:0] capword_r;
    logic [15:0] frames_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
  } ida_ctl_t;

  ida_ctl_t q;
  ida_ctl_t n;

  logic rx_pin;
  logic rx_sao;
  logic rx_d;
  logic tick;
  logic [4:0] nbit;
  logic [SLOT_IDX_W-1:0] nslot;
  logic active;
  logic known;
  logic [31:0] rd;

  ida_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({lnk.pin, lnk.sao}),
    .q({rx_pin, rx_sao})
  );

  always_comb begin
    n = q;
    rx_d = q.ctrl_r[CTRL_BUS_BIT] ? rx_sao : rx_pin;
    tick = (q.div_r == DIV_LAST);
    n.div_r = tick ? 8'h00 : q.div_r + 8'h01;
    if (tick) n.bclk_r = !q.bclk_r;

    if (q.bit_r == LAST_BIT) begin
      nbit = 5'h0;
      nslot = (q.slot_r == SLOT_MAX) ? '0 : q.slot_r + 6'h1;
    end else begin
      nbit = q.bit_r + 5'h1;
      nslot = q.slot_r;
    end
    active = q.ctrl_r[CTRL_RUN_BIT] && q.ctrl_r[CTRL_TX_BIT] && (nslot == q.tx_slot_r);

    // rising edge: the synchronised wire still shows the current bit
    if (tick && !q.bclk_r && q.ctrl_r[CTRL_RUN_BIT]) begin
      n.shift_r = {q.shift_r[SLOT_BITS-2:0], rx_d};
      if (q.bit_r == LAST_BIT && q.slot_r == q.cap_slot_r) n.capword_r = {q.shift_r[SLOT_BITS-2:0], rx_d};
    end
    // falling edge: advance and launch, half a period before the device samples
    if (tick && q.bclk_r) begin
      if (q.ctrl_r[CTRL_RUN_BIT]) begin
        n.bit_r = nbit;
        n.slot_r = nslot;
        n.fsync_r = (nbit == 5'h0) && (nslot == '0);
        if (n.fsync_r) n.frames_r = q.frames_r + 16'h0001;
      end else begin
        // parked on the last bit so the first frame opens at slot zero
        n.bit_r = LAST_BIT;
        n.slot_r = SLOT_MAX;
        n.fsync_r = 1'b0;
      end
      n.pin_out_r = active && !q.ctrl_r[CTRL_BUS_BIT] && q.txword_r[LAST_BIT - nbit];
      n.pin_oe_n_r = !(active && !q.ctrl_r[CTRL_BUS_BIT]);
      n.sao_out_r = active && q.ctrl_r[CTRL_BUS_BIT] && q.txword_r[LAST_BIT - nbit];
      n.sao_oe_n_r = !(active && q.ctrl_r[CTRL_BUS_BIT]);
    end

    // address decode for both read setup and write access
    known = 1'b1;
    rd = 32'h0;
    if (paddr == REG_CTRL) rd = {29'h0, q.ctrl_r};
    else if (paddr == REG_SLOT) rd = {18'h0, q.cap_slot_r, 2'h0, q.tx_slot_r};
    else if (paddr == REG_TXWORD) rd = {8'h00, q.txword_r};
    else if (paddr == REG_CAPWORD) rd = {8'h00, q.capword_r};
    else if (paddr == REG_STATUS) rd = {16'h0, q.frames_r};
    else known = 1'b0;

    if (psel && !penable) begin
      n.prdata_r = pwrite ? 32'h0 : rd;
      n.pslverr_r = !known;
    end
    if (psel && penable && pwrite) begin
      if (paddr == REG_CTRL) n.ctrl_r = pwdata[2:0];
      else if (paddr == REG_SLOT) begin
        n.tx_slot_r = pwdata[SLOT_TX_LSB +: SLOT_IDX_W];
        n.cap_slot_r = pwdata[SLOT_CAP_LSB +: SLOT_IDX_W];
      end else if (paddr == REG_TXWORD) n.txword_r = pwdata[SLOT_BITS-1:0];
    end

    // link clock parks low in reset: a divider with no known start would never leave the unknown state,
    // so the device end must stay in reset for a few link clocks after this reset lets go
    if (rst) begin
      n = '0;
      n.bit_r = LAST_BIT;
      n.slot_r = SLOT_MAX;
      n.pin_oe_n_r = 1'b1;
      n.sao_oe_n_r = 1'b1;
      n.ctrl_r = CTRL_RST;
      n.tx_slot_r = TX_SLOT_RST;
      n.cap_slot_r = CAP_SLOT_RST;
      n.txword_r = TXWORD_RST;
    end
  end

  always_ff @(posedge clk) begin
    q <= n;
  end

  assign prdata = q.prdata_r;
  assign pslverr = q.pslverr_r;
  assign pready = 1'b1;
  assign lnk.bclk = q.bclk_r;
  assign lnk.fsync = q.fsync_r;
  assign lnk.pin_ctl_out = q.pin_out_r;
  assign lnk.pin_ctl_oe_n = q.pin_oe_n_r;
  assign lnk.sao_ctl_out = q.sao_out_r;
  assign lnk.sao_ctl_oe_n = q.sao_oe_n_r;
endmodule

// File: sim/ida_assertions.sv
module ida_assertions #(
  parameter int FRAME_SLOTS = 8
) (
  input wire logic bclk, // link clock
  input wire logic rst, // link domain reset
  input wire logic fsync, // frame sync
  input wire logic pin_dev_oe_n, // device drives shared pin, low drives
  input wire logic sao_dev_oe_n, // device drives serial out, low drives
  input wire logic [ida_pkg::FUNC_W-1:0] pin_fn, // shared pin role
  input wire logic pin_ctl_oe_n, // controller drives shared pin, low drives
  input wire logic sao_ctl_oe_n // controller drives serial out, low drives
);
  import ida_pkg::*;
  logic dev_drv;
  logic ctl_drv;
  logic [4:0] dev_cnt_r;
  logic [4:0] ctl_cnt_r;
  logic [15:0] bit_r;
  logic [15:0] pos_w;
  logic seen_r;

  // pin drive in its gpio role is not slot traffic
  assign dev_drv = (!pin_dev_oe_n && pin_fn != PIN_FN_GPIO) || !sao_dev_oe_n;
  assign ctl_drv = !pin_ctl_oe_n || !sao_ctl_oe_n;
  // wire bit index within the frame, bit 0 is where fsync is seen high
  assign pos_w = fsync ? 16'h0 : bit_r;

  always_ff @(posedge bclk) begin
    if (rst) begin
      dev_cnt_r <= 5'h0;
      ctl_cnt_r <= 5'h0;
      bit_r <= 16'h0;
      seen_r <= 1'b0;
    end else begin
      dev_cnt_r <= dev_drv ? dev_cnt_r + 5'h1 : 5'h0;
      ctl_cnt_r <= ctl_drv ? ctl_cnt_r + 5'h1 : 5'h0;
      bit_r <= fsync ? 16'h1 : bit_r + 16'h1;
      seen_r <= seen_r | fsync;
    end
  end

  default clocking cb @(posedge bclk);
  endclocking
  default disable iff (rst);

  a_fsync_one_bit: assert property ($rose(fsync) |=> !fsync)
    else $error("frame sync high longer than one bit");
  a_frame_bit_count: assert property ($rose(fsync) && seen_r |-> bit_r == 16'(FRAME_SLOTS * SLOT_BITS))
    else $error("frame length wrong");
  a_dev_slot_len: assert property ($fell(dev_drv) |-> dev_cnt_r == 5'h18)
    else $error("device drive not one slot long");
  a_ctl_slot_len: assert property ($fell(ctl_drv) |-> ctl_cnt_r == 5'h18)
    else $error("controller drive not one slot long");
  a_dev_slot_start: assert property ($rose(dev_drv) |-> seen_r && (pos_w % 24) == 0)
    else $error("device drive off slot boundary");
  a_ctl_slot_start: assert property ($rose(ctl_drv) |-> seen_r && (pos_w % 24) == 0)
    else $error("controller drive off slot boundary");
  a_one_bus_only: assert property (!(!pin_dev_oe_n && !sao_dev_oe_n))
    else $error("device drives both wires");
  a_no_contention: assert property (!(!pin_dev_oe_n && !pin_ctl_oe_n) && !(!sao_dev_oe_n && !sao_ctl_oe_n))
    else $error("two drivers on one wire");
endmodule

// File: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ida_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dev_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [LIM_W-1:0] lim_gr = 12'h0;
  logic [BO_W-1:0] bo_gr = 13'h0;
  logic tx_en = 1'b0;
  logic [5:0] own_slot = 6'h0;
  logic [5:0] first_slot = 6'h0;
  logic [7:0] mask = 8'h00;
  logic lim_en = 1'b0;
  logic bo_en = 1'b0;
  logic [2:0] pin_fn = PIN_FN_ALIGN;
  logic keep_a = 1'b1;
  logic keep_s = 1'b0;
  logic gp_out = 1'b0;
  logic gp_oe_n = 1'b1;
  logic gpio_in;
  logic [LIM_W-1:0] al_lim;
  logic [BO_W-1:0] al_bo;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  ida_link_if lnk();
  ida_ctl i_ida_ctl (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  ida_dev i_ida_dev (.lnk(lnk), .rst(dev_rst), .lim_gr(lim_gr), .bo_gr(bo_gr), .gain_tx_enable(tx_en),
    .own_slot(own_slot), .group_first_slot(first_slot), .listen_slot_mask(mask), .limiter_align_enable(lim_en),
    .brownout_align_enable(bo_en), .shared_pin_function(pin_fn), .align_keeper_enable(keep_a),
    .sao_keeper_enable(keep_s), .gpio_out(gp_out), .gpio_oe_n(gp_oe_n), .gpio_in(gpio_in),
    .aligned_lim_gr(al_lim), .aligned_bo_gr(al_bo));
  ida_assertions #(.FRAME_SLOTS(FRAME_SLOTS)) i_ida_assertions (.bclk(lnk.bclk), .rst(dev_rst),
    .fsync(lnk.fsync), .pin_dev_oe_n(lnk.pin_dev_oe_n), .sao_dev_oe_n(lnk.sao_dev_oe_n),
    .pin_ctl_oe_n(lnk.pin_ctl_oe_n), .sao_ctl_oe_n(lnk.sao_ctl_oe_n), .pin_fn(pin_fn));

  always #4 clk = ~clk;

  task automatic complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // run is short of the ceiling by a margin of some nine frames
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, exp, q);
  endtask

  // changes land in slot 7, which no scenario transmits in, so no slot is cut short
  task automatic set_dev(input logic [5:0] f, input logic [5:0] o, input logic [7:0] m, input logic [1:0] en,
                         input logic [2:0] fn);
    @(posedge lnk.fsync);
    repeat (180) @(posedge lnk.bclk);
    first_slot <= f;
    own_slot <= o;
    mask <= m;
    lim_en <= en[1];
    bo_en <= en[0];
    pin_fn <= fn;
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 5; i++) rd_chk("register reset", 8'(4 * i), 32'h0);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    wr(REG_TXWORD, 32'hffffffff);
    rd_chk("txword width", REG_TXWORD, 32'h00ffffff);
  endtask

  task automatic t_tx();
    logic [1:0] en_t[5] = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h3};
    logic [2:0] fn_t[5] = '{PIN_FN_ALIGN, PIN_FN_ALIGN, PIN_FN_ALIGN, PIN_FN_OFF, PIN_FN_GPIO};
    logic [23:0] exp;
    lim_gr <= 12'hab7;
    bo_gr <= 13'h1c35;
    tx_en <= 1'b1;
    wr(REG_SLOT, 32'h00000300);
    for (int i = 0; i < 5; i++) begin
      set_dev(6'h0, 6'h3, 8'h00, en_t[i], fn_t[i]);
      wr(REG_CTRL, (fn_t[i] == PIN_FN_ALIGN) ? 32'h1 : 32'h5);
      repeat (2) @(posedge lnk.fsync);
      exp = (en_t[i] == 2'h3) ? {11'h55b, 13'h1c35} : (en_t[i] == 2'h2) ? 24'hab7000 : 24'h001c35;
      rd_chk("captured word", REG_CAPWORD, {8'h0, exp});
    end
    chk("pin keeper", 32'h1, {31'h0, lnk.pin_keep_en});
    chk("sao keeper", 32'h0, {31'h0, lnk.sao_keep_en});
  endtask

  task automatic t_quiet_gpio();
    logic [31:0] q;
    logic e;
    tx_en <= 1'b0;
    set_dev(6'h0, 6'h3, 8'h00, 2'h3, PIN_FN_ALIGN);
    wr(REG_CTRL, 32'h1);
    repeat (2) @(posedge lnk.fsync);
    rd_chk("silent slot", REG_CAPWORD, 32'h0);
    set_dev(6'h0, 6'h3, 8'h00, 2'h3, PIN_FN_GPIO);
    gp_out <= 1'b1;
    gp_oe_n <= 1'b0;
    repeat (4) @(posedge lnk.bclk);
    chk("gpio level", 32'h1, {31'h0, gpio_in});
    gp_out <= 1'b0;
    repeat (4) @(posedge lnk.bclk);
    chk("gpio level low", 32'h0, {31'h0, gpio_in});
    gp_oe_n <= 1'b1;
    @(posedge lnk.fsync);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    @(posedge lnk.fsync);
    rd_chk("frame count", REG_STATUS, q + 32'h1);
  endtask

  // controller sends 24'h7e1f00: limiter 7e0 in the shared layout, 7e1 in the limiter-only layout
  task automatic t_align();
    logic [5:0] f_t[6] = '{6'h0, 6'h0, 6'h0, 6'h0, 6'h4, 6'h4};
    logic [5:0] o_t[6] = '{6'h0, 6'h0, 6'h0, 6'h0, 6'h4, 6'h4};
    logic [5:0] c_t[6] = '{6'h1, 6'h1, 6'h1, 6'h1, 6'h5, 6'h6};
    logic [7:0] m_t[6] = '{8'h03, 8'h01, 8'h03, 8'h03, 8'h03, 8'h03};
    logic [1:0] en_t[6] = '{2'h3, 2'h3, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [11:0] el_t[6] = '{12'h7e0, 12'h010, 12'h010, 12'h7e1, 12'h7e0, 12'h010};
    logic [12:0] eb_t[6] = '{13'h1f00, 13'h1000, 13'h1f00, 13'h1000, 13'h1f00, 13'h1000};
    lim_gr <= 12'h010;
    bo_gr <= 13'h1000;
    tx_en <= 1'b1;
    wr(REG_TXWORD, 32'h007e1f00);
    for (int i = 0; i < 6; i++) begin
      set_dev(f_t[i], o_t[i], m_t[i], en_t[i], PIN_FN_ALIGN);
      wr(REG_SLOT, {26'h0, c_t[i]});
      wr(REG_CTRL, 32'h3);
      repeat (2) @(posedge lnk.fsync);
      repeat (8) @(posedge lnk.bclk);
      chk("aligned limiter", {20'h0, el_t[i]}, {20'h0, al_lim});
      chk("aligned brownout", {19'h0, eb_t[i]}, {19'h0, al_bo});
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge lnk.bclk);
    dev_rst <= 1'b0;
    t_regs();
    wr(REG_CTRL, 32'h1);
    t_tx();
    t_quiet_gpio();
    t_align();
    complete_run();
  end
endmodule
